//--- verilog/pml_top.sv
`timescale 1ns/1ns
// Functional notes
// RQ1: Reset fetches vector at top of memory
// RQ2: Wait gates CPU clock, bus stays on
// RQ3: Wait or stop entry clears interrupt mask
// RQ4: Any interrupt wakes from wait
// RQ5: Wait allows background commands only, status commands flag an error
// RQ6: Background command in wait enters debug
// RQ7: Stop enters stop3 only if permitted
// RQ8: Stop3 halts clocks, standby regulator
// RQ9: Stop3 keeps all register state
// RQ10: Listed wake sources leave stop3
// RQ11: Reset exit fetches reset vector
// RQ12: RTC clock off when prescaler zero
// RQ13: Debug enabled keeps debug clock, regulation
// RQ14: Background wakes stop into debug
// RQ15: Detect in stop keeps regulator active
// RQ16: Detector off in stop unless enabled
// RQ17: Detector runs when enabled, trip selectable
// RQ18: Power-on sets both reset status bits
// RQ19: Detect reset holds until supply recovers
// RQ20: Warning sets flag and interrupt
// RQ21: Four warning thresholds per trip setting
// RQ22: Acknowledge clears flag if warning gone
// RQ23: Detect reset enable is write once
// RQ24: Analog outputs synchronised before use
module pml_top (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [17:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cpu_wait_exec,
	input  wire logic        cpu_stop_exec,
	input  wire logic        stop_permit,
	input  wire logic        debug_enable,
	input  wire logic        ics_keep_osc,
	input  wire logic        ics_keep_irc,
	input  wire logic [2:0]  rtc_prescaler_select,
	input  wire logic        irq_any,
	input  wire logic [6:0]  wake_src,
	input  wire logic        dbg_background_cmd,
	input  wire logic        dbg_status_cmd,
	input  wire logic        dbg_mem_cmd,
	input  wire logic        dbg_exit,
	input  wire logic        reset_pin,
	input  wire logic        por_raw,
	input  wire logic        detect_low_raw,
	input  wire logic        detect_high_raw,
	input  wire logic [7:0]  warn_raw,
	output logic             cpu_clk_en,
	output logic             bus_clk_en,
	output logic             debug_clk_en,
	output logic             osc_en,
	output logic             irc_en,
	output logic             rtc_clk_en,
	output logic             regulator_full,
	output logic             standby,
	output logic             detector_en,
	output logic [1:0]       detector_trip,
	output logic [3:0]       warn_level_sel,
	output logic             clear_int_mask,
	output logic             wake_to_isr,
	output logic             fetch_reset_vector,
	output logic [15:0]      vector_addr,
	output logic             system_reset,
	output logic             warn_irq,
	output logic             dbg_cmd_accept,
	output logic             dbg_cmd_error,
	output logic             dbg_active,
	output logic [1:0]       mode
);
	// ----------------------------------------
	// Analog input synchronisers
	// ----------------------------------------
	localparam int SW = 4;
	pml_sync_if #(.W(SW)) sif ();
	logic por_s;
	logic low_s;
	logic high_s;
	logic warn_s;
	logic [2:0] wsel;
	logic [7:0] ctrl1_r;
	logic [7:0] ctrl2_r;

	always_comb begin
		wsel = {ctrl2_r[pml_pkg::C2_DTRIP], ctrl2_r[1:0]};
	end
	assign sif.raw = {por_raw, detect_low_raw, detect_high_raw, warn_raw[wsel]};
	pml_sync #(.W(SW)) u_sync (
		.clk  (clk),
		.reset(reset),
		.port (sif.dst)
	);
	assign por_s  = sif.sync[3];                                   // RQ24
	assign low_s  = sif.sync[2];
	assign high_s = sif.sync[1];
	assign warn_s = sif.sync[0];                                   // RQ21

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic         dre_locked_r;
	logic [1:0]   srs_r;
	logic         lv_hold_r;
	pml_pkg::pml_mode_type mode_r;
	pml_pkg::pml_mode_type mode_nxt;
	logic         det_stop_r;
	logic         dbg_stop_r;
	logic         vec_pending_r;
	logic         wr;
	logic         rd_ok;
	logic [15:0]  idx;
	logic         detect_s;
	logic         det_active;

	assign idx = paddr[17:2];
	assign wr  = psel && penable && pwrite;
	assign rd_ok = idx == pml_pkg::IDX_CTRL1 || idx == pml_pkg::IDX_CTRL2 ||
		idx == pml_pkg::IDX_MODE || idx == pml_pkg::IDX_RESET;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !rd_ok;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			case (idx)
				pml_pkg::IDX_CTRL1: prdata <= {24'h00_0000, ctrl1_r};
				pml_pkg::IDX_CTRL2: prdata <= {24'h00_0000, ctrl2_r};
				pml_pkg::IDX_MODE:  prdata <= {30'h0000_0000, mode_r};
				pml_pkg::IDX_RESET: prdata <= {30'h0000_0000, srs_r};
				default:            prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Control 1: flag is hardware set, ack reads as zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl1_r      <= pml_pkg::CTRL1_RESET;
			dre_locked_r <= 1'b0;
		end else begin
			if (wr && idx == pml_pkg::IDX_CTRL1) begin
				ctrl1_r[pml_pkg::C1_WIE] <= pwdata[pml_pkg::C1_WIE];
				ctrl1_r[pml_pkg::C1_DSE] <= pwdata[pml_pkg::C1_DSE];
				ctrl1_r[pml_pkg::C1_DE]  <= pwdata[pml_pkg::C1_DE];
				ctrl1_r[1:0]             <= pwdata[1:0];
				dre_locked_r             <= 1'b1;                  // RQ23
				if (!dre_locked_r)
					ctrl1_r[pml_pkg::C1_DRE] <= pwdata[pml_pkg::C1_DRE]; // RQ23
			end
			// Set beats ack: live warning keeps flag high
			if (det_active && warn_s)
				ctrl1_r[pml_pkg::C1_WFLAG] <= 1'b1;                 // RQ20
			else if (wr && idx == pml_pkg::IDX_CTRL1 && pwdata[pml_pkg::C1_WACK])
				ctrl1_r[pml_pkg::C1_WFLAG] <= 1'b0;                 // RQ22
			ctrl1_r[pml_pkg::C1_WACK] <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl2_r <= pml_pkg::CTRL2_RESET;
		end else if (wr && idx == pml_pkg::IDX_CTRL2) begin
			ctrl2_r <= {5'h00, pwdata[2:0]};
		end
	end

	// ----------------------------------------
	// Low-voltage detection and reset source
	// ----------------------------------------
	assign detect_s   = ctrl2_r[pml_pkg::C2_DTRIP] ? high_s : low_s;       // RQ17
	assign det_active = ctrl1_r[pml_pkg::C1_DE] &&
		(mode_r != pml_pkg::PML_STOP || det_stop_r);                      // RQ16
	assign detector_en   = det_active;                                     // RQ17
	assign detector_trip = {ctrl2_r[pml_pkg::C2_DTRIP], !ctrl2_r[pml_pkg::C2_DTRIP]};
	assign warn_level_sel = 4'h1 << ctrl2_r[1:0];                          // RQ21
	assign warn_irq = ctrl1_r[pml_pkg::C1_WFLAG] && ctrl1_r[pml_pkg::C1_WIE] &&
		ctrl1_r[pml_pkg::C1_DE];                                           // RQ20

	// Hold persists across the reset it causes; async clear only on the reset input
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lv_hold_r <= 1'b0;
			srs_r     <= 2'b00;
		end else begin
			if (por_s) begin
				lv_hold_r <= 1'b1;                                  // RQ18
				srs_r     <= 2'b11;                                 // RQ18
			end else if (det_active && ctrl1_r[pml_pkg::C1_DRE] && detect_s) begin
				lv_hold_r <= 1'b1;                                  // RQ19
				srs_r     <= 2'b01;                                 // RQ19
			end else if (lv_hold_r && !low_s && !detect_s) begin
				lv_hold_r <= 1'b0;
			end
		end
	end
	assign system_reset = por_s || lv_hold_r || reset_pin;            // RQ11

	// ----------------------------------------
	// Power mode state machine
	// ----------------------------------------
	logic wake_stop;
	assign wake_stop = |wake_src;                                      // RQ10

	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			pml_pkg::PML_RUN: begin
				if (cpu_wait_exec)
					mode_nxt = pml_pkg::PML_WAIT;
				else if (cpu_stop_exec && stop_permit)
					mode_nxt = pml_pkg::PML_STOP;                      // RQ7
			end
			pml_pkg::PML_WAIT: begin
				if (dbg_background_cmd)
					mode_nxt = pml_pkg::PML_BKGD;                      // RQ6
				else if (irq_any)
					mode_nxt = pml_pkg::PML_RUN;                       // RQ4
			end
			pml_pkg::PML_STOP: begin
				if (dbg_background_cmd && dbg_stop_r)
					mode_nxt = pml_pkg::PML_BKGD;                      // RQ14
				else if (wake_stop)
					mode_nxt = pml_pkg::PML_RUN;                       // RQ10
			end
			pml_pkg::PML_BKGD: begin
				if (dbg_exit)
					mode_nxt = pml_pkg::PML_RUN;
			end
			default: mode_nxt = pml_pkg::PML_RUN;
		endcase
	end

	// Reset pin returns to run through system reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_r <= pml_pkg::PML_RUN;
		end else if (reset_pin || lv_hold_r || por_s) begin
			mode_r <= pml_pkg::PML_RUN;                             // RQ11
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// Stop options latched at stop entry
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			det_stop_r <= 1'b0;
			dbg_stop_r <= 1'b0;
		end else if (mode_r == pml_pkg::PML_RUN && mode_nxt == pml_pkg::PML_STOP) begin
			det_stop_r <= ctrl1_r[pml_pkg::C1_DSE] || debug_enable;  // RQ16
			dbg_stop_r <= debug_enable;                              // RQ13
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			vec_pending_r <= 1'b1;
		end else begin
			vec_pending_r <= system_reset;
		end
	end
	assign fetch_reset_vector = vec_pending_r;                       // RQ1
	assign vector_addr        = pml_pkg::RESET_VECTOR;

	// ----------------------------------------
	// Mode outputs
	// ----------------------------------------
	logic in_stop;
	assign in_stop = mode_r == pml_pkg::PML_STOP;
	assign mode    = mode_r;
	assign cpu_clk_en   = mode_r == pml_pkg::PML_RUN || mode_r == pml_pkg::PML_BKGD; // RQ2
	assign bus_clk_en   = !in_stop;                                     // RQ8
	assign debug_clk_en = !in_stop || dbg_stop_r;                       // RQ13
	assign osc_en       = !in_stop || ics_keep_osc;                     // RQ8
	assign irc_en       = !in_stop || ics_keep_irc;                     // RQ8
	assign rtc_clk_en   = rtc_prescaler_select != 3'b000;               // RQ12
	assign regulator_full = !in_stop || dbg_stop_r ||
		(det_stop_r && ctrl1_r[pml_pkg::C1_DE]);                       // RQ15
	// State retained: no register here is cleared by stop
	assign standby      = in_stop;                                      // RQ9
	assign clear_int_mask = mode_r == pml_pkg::PML_RUN &&
		(cpu_wait_exec || (cpu_stop_exec && stop_permit));               // RQ3
	assign wake_to_isr  = (mode_r == pml_pkg::PML_WAIT && irq_any && !dbg_background_cmd) ||
		(in_stop && wake_stop && !(dbg_background_cmd && dbg_stop_r));   // RQ4
	assign dbg_active   = mode_r == pml_pkg::PML_BKGD;

	// Debug command filtering in low-power modes
	always_comb begin
		dbg_cmd_accept = 1'b0;
		dbg_cmd_error  = 1'b0;
		case (mode_r)
			pml_pkg::PML_WAIT, pml_pkg::PML_STOP: begin
				dbg_cmd_accept = dbg_background_cmd &&
					(mode_r == pml_pkg::PML_WAIT || dbg_stop_r);        // RQ5
				dbg_cmd_error  = dbg_status_cmd;                        // RQ5
			end
			default: dbg_cmd_accept = dbg_background_cmd || dbg_status_cmd ||
				dbg_mem_cmd;
		endcase
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_wait_entry: assert property (@(posedge clk) disable iff (reset)
		mode_r == pml_pkg::PML_RUN && cpu_wait_exec && !system_reset
		|=> mode_r == pml_pkg::PML_WAIT) // RQ2
		else $error("wait not entered");
	a_stop_gate: assert property (@(posedge clk) disable iff (reset)
		mode_r == pml_pkg::PML_RUN && cpu_stop_exec && !stop_permit && !cpu_wait_exec
		|=> mode_r == pml_pkg::PML_RUN) // RQ7
		else $error("stop entered without permit");
	a_wait_clk: assert property (@(posedge clk) disable iff (reset)
		mode_r == pml_pkg::PML_WAIT |-> !cpu_clk_en && bus_clk_en && regulator_full) // RQ2
		else $error("wait clocking wrong");
	a_wait_wake: assert property (@(posedge clk) disable iff (reset)
		mode_r == pml_pkg::PML_WAIT && irq_any && !dbg_background_cmd && !system_reset
		|=> mode_r == pml_pkg::PML_RUN) // RQ4
		else $error("wait wake missed");
	a_dbg_stop_reg: assert property (@(posedge clk) disable iff (reset)
		in_stop && dbg_stop_r |-> regulator_full && debug_clk_en) // RQ13
		else $error("debug stop regulation lost");
	a_warn_flag: assert property (@(posedge clk) disable iff (reset)
		det_active && warn_s |=> ctrl1_r[pml_pkg::C1_WFLAG]) // RQ20
		else $error("warning flag not set");
	a_dre_once: assert property (@(posedge clk) disable iff (reset)
		dre_locked_r |=> $stable(ctrl1_r[pml_pkg::C1_DRE])) // RQ23
		else $error("reset enable changed twice");
	a_rtc_off: assert property (@(posedge clk) disable iff (reset)
		rtc_prescaler_select == 3'b000 |-> !rtc_clk_en) // RQ12
		else $error("rtc clock not gated");
	a_por_srs: assert property (@(posedge clk) disable iff (reset)
		por_s |=> srs_r == 2'b11 && lv_hold_r) // RQ18
		else $error("power-on status wrong");
endmodule

//--- verilog/pml_pkg.sv
package pml_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	// 0x3041 is not a multiple of four: printed offsets are indices
	localparam logic [15:0] IDX_CTRL1   = 16'h3040;
	localparam logic [15:0] IDX_CTRL2   = 16'h3041;
	localparam logic [15:0] IDX_MODE    = 16'h3042;
	localparam logic [15:0] IDX_RESET   = 16'h3043;
	localparam logic [7:0]  CTRL1_RESET = 8'h1c;
	localparam logic [7:0]  CTRL2_RESET = 8'h00;

	// Control 1 fields
	localparam int C1_WFLAG  = 7;
	localparam int C1_WACK   = 6;
	localparam int C1_WIE    = 5;
	localparam int C1_DRE    = 4;
	localparam int C1_DSE    = 3;
	localparam int C1_DE     = 2;
	// Control 2 fields
	localparam int C2_DTRIP  = 2;
	localparam int C2_WTRIP  = 0;

	// Reset vector
	localparam logic [15:0] RESET_VECTOR = 16'hfffe;

	typedef enum logic [1:0] {
		PML_RUN  = 2'b00,
		PML_WAIT = 2'b01,
		PML_STOP = 2'b11,
		PML_BKGD = 2'b10
	} pml_mode_type;
endpackage

//--- verilog/pml_sync_if.sv
`timescale 1ns/1ns
interface pml_sync_if #(parameter int W = 4);
	logic [W-1:0] raw;
	logic [W-1:0] sync;
	modport src (output raw, input sync);
	modport dst (input raw, output sync);
endinterface

//--- verilog/pml_sync.sv
`timescale 1ns/1ns
module pml_sync #(
	parameter int W = 4
) (
	input  wire logic clk,
	input  wire logic reset,
	pml_sync_if.dst   port
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// Stage one feeds stage two only
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= port.raw;
			sync_r <= meta_r;
		end
	end
	assign port.sync = sync_r;
endmodule

//--- testbench/pml_cpu_model.sv
`timescale 1ns/1ns
module pml_cpu_model (
	input  wire logic       clk,
	input  wire logic [1:0] mode,
	output logic      [3:0] cmd,
	output logic      [6:0] wake_src,
	output logic            irq_any
);
	// ----------------------------------------
	// Core, debug pod and wake sources
	// ----------------------------------------
	// Command bits: wait, stop, background, status
	initial begin
		cmd = 4'h0;
		wake_src = 7'h00;
		irq_any = 1'b0;
	end

	task automatic pulse(input int k);
		@(posedge clk) cmd[k] <= 1'b1;
		@(posedge clk) cmd[k] <= 1'b0;
	endtask

	// Level sources stay up until the core is back in run
	task automatic wake(input logic [6:0] src, input logic irq);
		int n;
		n = 0;
		@(posedge clk);
		wake_src <= src;
		irq_any <= irq;
		do begin
			@(posedge clk);
			n++;
		end while (mode !== 2'b00 && n < 50);
		wake_src <= 7'h00;
		irq_any <= 1'b0;
	endtask
endmodule

//--- testbench/pml_top_bench.sv
`timescale 1ns/1ns
module pml_top_bench;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr, err;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        stop_permit, debug_enable, ics_keep_osc, ics_keep_irc, reset_pin, irq_any;
	logic        por_raw, detect_low_raw, detect_high_raw, dbg_exit, dbg_mem_cmd;
	logic [2:0]  rtc_prescaler_select;
	logic [6:0]  wake_src;
	logic [7:0]  warn_raw;
	logic [3:0]  cmd, warn_level_sel;
	logic [1:0]  mode, detector_trip;
	logic [15:0] vector_addr;
	logic        cpu_clk_en, bus_clk_en, debug_clk_en, osc_en, irc_en, rtc_clk_en;
	logic        regulator_full, standby, detector_en, clear_int_mask, wake_to_isr;
	logic        fetch_reset_vector, system_reset, warn_irq, dbg_cmd_accept, dbg_cmd_error;
	logic        dbg_active;
	int          failures, total_checks;
	int          cnt [4];

	pml_top dut (
		.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .cpu_wait_exec(cmd[0]), .cpu_stop_exec(cmd[1]), .stop_permit,
		.debug_enable, .ics_keep_osc, .ics_keep_irc, .rtc_prescaler_select, .irq_any,
		.wake_src, .dbg_background_cmd(cmd[2]), .dbg_status_cmd(cmd[3]), .dbg_mem_cmd,
		.dbg_exit, .reset_pin, .por_raw, .detect_low_raw, .detect_high_raw, .warn_raw,
		.cpu_clk_en, .bus_clk_en, .debug_clk_en, .osc_en, .irc_en, .rtc_clk_en,
		.regulator_full, .standby, .detector_en, .detector_trip, .warn_level_sel,
		.clear_int_mask, .wake_to_isr, .fetch_reset_vector, .vector_addr, .system_reset,
		.warn_irq, .dbg_cmd_accept, .dbg_cmd_error, .dbg_active, .mode
	);
	pml_cpu_model cpu (.clk, .mode, .cmd, .wake_src, .irq_any);

	// ----------------------------------------
	// Clock, event counters, tasks
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Pulses are counted at the edge so short ones are not missed
	always @(posedge clk) begin
		if (clear_int_mask === 1'b1) cnt[0]++;
		if (wake_to_isr === 1'b1) cnt[1]++;
		if (dbg_cmd_error === 1'b1) cnt[2]++;
		if (dbg_cmd_accept === 1'b1) cnt[3]++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, idx, 2'b00, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100) failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic settle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic leave_dbg();
		@(posedge clk) dbg_exit <= 1'b1;
		@(posedge clk) dbg_exit <= 1'b0;
		#1;
		chk(mode, pml_pkg::PML_RUN);
	endtask

	function automatic logic [2:0] exp_reg(input logic de, dse, dbg);
		logic full;
		full = dbg | (de & dse);
		return {dbg, full, 1'b1};
	endfunction

	task automatic results();
		if (failures == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		results();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		logic de, dse, t;
		logic [1:0] s;
		int c;
		void'($urandom(32'he1d6));
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{stop_permit, debug_enable, ics_keep_osc, ics_keep_irc, reset_pin} = '0;
		{por_raw, detect_low_raw, detect_high_raw, dbg_exit, dbg_mem_cmd} = '0;
		rtc_prescaler_select = 3'h0;
		warn_raw = 8'h00;
		reset = 1'b1;
		settle(3);
		chk({fetch_reset_vector, vector_addr}, {1'b1, pml_pkg::RESET_VECTOR});
		@(posedge clk) reset <= 1'b0;
		settle(1);
		chk({cpu_clk_en, bus_clk_en, regulator_full}, 3'h7);
		apb(0, pml_pkg::IDX_CTRL1, 0);
		chk(rd[7:0], pml_pkg::CTRL1_RESET);
		apb(0, 16'h3050, 0);
		chk({err, rd}, {1'b1, 32'h0000_0000});
		apb(1, pml_pkg::IDX_CTRL1, 32'h0000_0000);
		apb(1, pml_pkg::IDX_CTRL1, 32'h0000_0010);
		apb(0, pml_pkg::IDX_CTRL1, 0);
		chk(rd[4], 1'b0);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk) rtc_prescaler_select <= 3'(i);
			settle(1);
			chk(rtc_clk_en, i != 0);
		end
		c = cnt[0];
		cpu.pulse(0);
		#1;
		chk({mode, cpu_clk_en, bus_clk_en, regulator_full}, {pml_pkg::PML_WAIT, 3'h3});
		cpu.pulse(3);
		settle(1);
		chk(cnt[0] != c, 1'b1);
		chk({cnt[2] > 0, mode}, {1'b1, pml_pkg::PML_WAIT});
		cpu.pulse(2);
		#1;
		chk({mode, dbg_active}, {pml_pkg::PML_BKGD, 1'b1});
		leave_dbg();
		cpu.pulse(0);
		c = cnt[1];
		cpu.wake(7'h00, 1'b1);
		#1;
		chk({mode, cnt[1] != c}, {pml_pkg::PML_RUN, 1'b1});
		apb(1, pml_pkg::IDX_CTRL2, 32'h0000_0005);
		for (int i = 0; i < 12; i++) begin
			de = 1'($urandom);
			dse = 1'($urandom);
			apb(1, pml_pkg::IDX_CTRL1, {28'h000_0000, dse, de, 2'b00});
			@(posedge clk) {stop_permit, debug_enable, ics_keep_osc, ics_keep_irc} <= 4'($urandom);
			#1;
			chk(detector_en, de);
			cpu.pulse(1);
			#1;
			if (stop_permit !== 1'b1) begin
				chk(mode, pml_pkg::PML_RUN);
			end else begin
				chk(mode, pml_pkg::PML_STOP);
				chk({cpu_clk_en, bus_clk_en, osc_en, irc_en}, {2'b00, ics_keep_osc, ics_keep_irc});
				chk({debug_clk_en, regulator_full, standby}, exp_reg(de, dse, debug_enable));
				chk(detector_en, de & (dse | debug_enable));
				c = cnt[1];
				cpu.wake(7'h01 << ($urandom % 7), 1'b0);
				#1;
				chk({mode, cnt[1] != c}, {pml_pkg::PML_RUN, 1'b1});
			end
		end
		apb(0, pml_pkg::IDX_CTRL2, 0);
		chk(rd[2:0], 3'h5);
		@(posedge clk) {stop_permit, debug_enable} <= 2'b11;
		cpu.pulse(1);
		c = cnt[2];
		cpu.pulse(3);
		cpu.pulse(2);
		#1;
		chk({cnt[2] != c, mode, dbg_active}, {1'b1, pml_pkg::PML_BKGD, 1'b1});
		c = cnt[3];
		cpu.pulse(3);
		settle(1);
		chk(cnt[3] != c, 1'b1);
		c = cnt[3];
		@(posedge clk) dbg_mem_cmd <= 1'b1;
		@(posedge clk) dbg_mem_cmd <= 1'b0;
		#1;
		chk(cnt[3] != c, 1'b1);
		leave_dbg();
		t = 1'($urandom);
		s = 2'($urandom);
		apb(1, pml_pkg::IDX_CTRL2, {29'h000_0000, t, s});
		apb(1, pml_pkg::IDX_CTRL1, 32'h0000_0024);
		@(posedge clk) warn_raw <= ~(8'h01 << {t, s});
		settle(4);
		chk({warn_irq, warn_level_sel}, {1'b0, 4'h1 << s});
		@(posedge clk) warn_raw <= 8'h01 << {t, s};
		settle(1);
		chk(warn_irq, 1'b0);
		settle(3);
		chk(warn_irq, 1'b1);
		apb(1, pml_pkg::IDX_CTRL1, 32'h0000_0064);
		apb(0, pml_pkg::IDX_CTRL1, 0);
		chk(rd[7], 1'b1);
		@(posedge clk) warn_raw <= 8'h00;
		settle(4);
		apb(1, pml_pkg::IDX_CTRL1, 32'h0000_0064);
		apb(0, pml_pkg::IDX_CTRL1, 0);
		chk({rd[7], warn_irq}, 2'b00);
		@(posedge clk) por_raw <= 1'b1;
		settle(3);
		chk(system_reset, 1'b1);
		@(posedge clk) por_raw <= 1'b0;
		settle(10);
		apb(0, pml_pkg::IDX_RESET, 0);
		chk(rd[1:0], 2'b11);
		cpu.pulse(0);
		@(posedge clk) reset_pin <= 1'b1;
		settle(1);
		chk({system_reset, mode}, {1'b1, pml_pkg::PML_RUN});
		@(posedge clk) reset_pin <= 1'b0;
		#1;
		chk(fetch_reset_vector, 1'b1);
		@(posedge clk) reset <= 1'b1;
		settle(2);
		@(posedge clk) reset <= 1'b0;
		apb(1, pml_pkg::IDX_CTRL1, 32'h0000_0014);
		apb(1, pml_pkg::IDX_CTRL2, {29'h000_0000, t, 2'b00});
		@(posedge clk) {detect_high_raw, detect_low_raw} <= {t, !t};
		settle(4);
		chk({system_reset, mode}, {1'b1, pml_pkg::PML_RUN});
		@(posedge clk) {detect_high_raw, detect_low_raw} <= 2'b00;
		settle(5);
		chk(system_reset, 1'b0);
		apb(0, pml_pkg::IDX_RESET, 0);
		chk(rd[1:0], 2'b01);
		results();
	end
endmodule
